// file: xps_chain.v
/*
 * Serial configuration chain of one crosspoint device: frame scanning,
 * address decrement while forwarding, staged load, read-back insertion.
 * Assumes sclk, si and load are pins sampled by a faster clk (40 MHz),
 * so each shift clock level lasts several clk periods.
 */
// Contract
// - 30-bit word, MSB first, seven fields
// - Frames 1F load, 1E read, scanned continuously; code holds the scan off while a framed word is still arriving
// - Code 0 off, 1-4 inputs, rest invalid
// - Addressed load fills staging; strobe copies active
// - Read frame enters read-back handling
// - Addressed read inserts active configuration both outputs
// - Downstream devices decrement returned word address
// - Sender puts returned row address on column output
// - After insertion, revert to write handling
// - Seven shift clocks latency per device
// - Words ripple via row and column outputs
// - Staging holds configuration until load strobe
// - Forwarded word address decremented modulo 64
`timescale 1ns/1ps
`default_nettype none
`include "xps_defines.vh"

module xps_chain
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        sclk_pin,
    input  wire        si_pin,
    input  wire        load_pin,
    output wire        row_forward_out,
    output wire        row_forward_clock,
    output wire        column_forward_out,
    output wire        column_forward_clock,
    output wire [2:0]  output_one_select,
    output wire [2:0]  output_two_select,
    output wire [2:0]  output_three_select,
    output wire [2:0]  output_four_select,
    output wire [3:0]  output_enable,
    output wire [7:0]  input_index
);

    // ============================================================
    // Helper functions
    // ============================================================
    // Address minus one, wrapping from zero to all ones
    function [5:0] dec6;
        input [5:0] v;
        begin
            dec6 = v - 6'h01;
        end
    endfunction

    // Pick one bit of a field, index counted from the field MSB
    function fbit;
        input [11:0] v;
        input [4:0]  idx;
        input [3:0]  msb;
        reg   [4:0]  pos;
        begin
            pos  = {1'b0, msb} - idx;
            fbit = v[pos[3:0]];
        end
    endfunction

    // Selection code to enable: invalid codes stay off
    function sel_en;
        input [2:0] c;
        begin
            sel_en = (c != `XPS_SEL_OFF) && (c <= `XPS_SEL_MAX);
        end
    endfunction

    // Selection code to 2-bit input number
    function [1:0] sel_idx;
        input [2:0] c;
        reg   [2:0] t;
        begin
            t       = c - 3'h1;
            sel_idx = sel_en(c) ? t[1:0] : 2'h0;
        end
    endfunction

    // ============================================================
    // Pin sampling and shift clock edge
    // ============================================================
    wire [2:0] pins_s;                 // Synchronised sclk, si, load
    wire       sclk_s;
    wire       si_s;
    wire       load_s;
    reg        sclk_prev_q;            // Last sclk level, for edge find
    wire       shift;                  // One clk pulse per sclk rise

    xps_sync #(.W(3)) u_sync
    (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .d      ({sclk_pin, si_pin, load_pin}),
        .q      (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign si_s   = pins_s[1];
    assign load_s = pins_s[0];
    assign shift  = sclk_s & ~sclk_prev_q;

    // ============================================================
    // Datapath state
    // ============================================================
    reg  [29:0] sr_q;                  // Incoming bits, [0] newest
    reg         ovalid_q;              // Tap bit belongs to a framed word
    reg  [4:0]  ocnt_q;                // Word index of the tap bit
    reg         is_read_q;             // Current word is a read
    reg  [5:0]  rowm1_q;               // Row minus one, column stream
    reg  [5:0]  colm1_q;               // Column minus one, row stream
    reg         hit_q;                 // Word addresses this device
    reg         rb_q;                  // Read-back insertion armed
    reg  [11:0] rbdata_q;              // Configuration being returned
    reg  [11:0] stage_q;               // Staging register
    reg  [11:0] active_q;              // Active configuration
    reg         row_out_q;
    reg         col_out_q;
    reg         row_clk_q;
    reg         col_clk_q;
    reg  [3:0]  oe_q;                  // Decoded output enables
    reg  [7:0]  idx_q;                 // Decoded input numbers

    reg  [29:0] sr_d;
    reg         ovalid_d;
    reg  [4:0]  ocnt_d;
    reg         start;                 // Recognised start frame now
    reg         row_bit;
    reg         col_bit;

    // ============================================================
    // Next shift state and outgoing bits
    // ============================================================
    always @*
    begin
        sr_d     = {sr_q[`XPS_SR_MSB-1:0], si_s};
        // Scan the stream unless a word is still arriving
        start    = (sr_d[5:0] == `XPS_FRAME_LOAD ||
                    sr_d[5:0] == `XPS_FRAME_READ) &&
                   !(ovalid_q && ocnt_q < `XPS_SCAN_LIMIT);
        ovalid_d = ovalid_q && (ocnt_q != `XPS_WORD_LAST);
        ocnt_d   = ocnt_q + 5'h01;
        if (start)
        begin
            ovalid_d = 1'b1;
            ocnt_d   = 5'h00;
        end
        // Unframed bits leave exactly as they came in
        row_bit = sr_q[`XPS_TAP];
        col_bit = sr_q[`XPS_TAP];
        if (ovalid_q)
        begin
            // Row stream carries column minus one
            if (ocnt_q >= `XPS_COL_FIRST && ocnt_q <= `XPS_COL_LAST)
                row_bit = fbit({6'h00, colm1_q}, ocnt_q - `XPS_COL_FIRST,
                               4'h5);
            // Column stream carries row minus one
            if (ocnt_q >= `XPS_ROW_FIRST && ocnt_q <= `XPS_ROW_LAST)
                col_bit = fbit({6'h00, rowm1_q}, ocnt_q - `XPS_ROW_FIRST,
                               4'h5);
            // Read-back fills the selection fields of both streams
            if (rb_q && ocnt_q >= `XPS_CFG_FIRST)
            begin
                row_bit = fbit(rbdata_q, ocnt_q - `XPS_CFG_FIRST,
                               4'hb);
                col_bit = row_bit;
            end
        end
    end

    // ============================================================
    // Shift, decode and forward on each shift clock rise
    // ============================================================
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_prev_q <= 1'b0;
            sr_q        <= 30'h0000_0000;
            ovalid_q    <= 1'b0;
            ocnt_q      <= 5'h00;
            is_read_q   <= 1'b0;
            rowm1_q     <= 6'h00;
            colm1_q     <= 6'h00;
            hit_q       <= 1'b0;
            rb_q        <= 1'b0;
            rbdata_q    <= `XPS_CFG_RESET;
            stage_q     <= `XPS_CFG_RESET;
            active_q    <= `XPS_CFG_RESET;
            row_out_q   <= 1'b0;
            col_out_q   <= 1'b0;
            row_clk_q   <= 1'b1;
            col_clk_q   <= 1'b1;
        end
        else if (ce)
        begin
            sclk_prev_q <= sclk_s;
            // Inverted clock rises mid-bit, away from data changes
            row_clk_q   <= ~sclk_s;
            col_clk_q   <= ~sclk_s;
            if (shift)
            begin
                sr_q      <= sr_d;
                ovalid_q  <= ovalid_d;
                ocnt_q    <= ocnt_d;
                // Tap plus output flop gives seven edges of delay
                row_out_q <= row_bit;
                col_out_q <= col_bit;
                if (start)
                    is_read_q <= (sr_d[5:0] == `XPS_FRAME_READ);
                // Row field complete: ready for column stream
                if (ovalid_d && ocnt_d == `XPS_ROW_FIRST)
                    rowm1_q <= dec6(sr_d[5:0]);
                // Column field complete: decide on addressing
                if (ovalid_d && ocnt_d == `XPS_COL_FIRST)
                begin
                    colm1_q <= dec6(sr_d[5:0]);
                    hit_q   <= (sr_d[11:6] == `XPS_ADDR_ZERO) &&
                               (sr_d[5:0] == `XPS_ADDR_ZERO);
                    if (is_read_q && sr_d[11:6] == `XPS_ADDR_ZERO &&
                        sr_d[5:0] == `XPS_ADDR_ZERO)
                    begin
                        rb_q     <= 1'b1;
                        rbdata_q <= active_q;
                    end
                end
                // Last bit of the word has arrived, D11:D0 in sr_d[11:0]
                if (ovalid_d && ocnt_d == `XPS_WORD_IN)
                begin
                    if (hit_q && !is_read_q)
                        stage_q <= sr_d[11:0];
                    hit_q <= 1'b0;
                end
                // Insertion done: back to write handling
                if (ovalid_q && ocnt_q == `XPS_WORD_LAST)
                    rb_q <= 1'b0;
                // Load strobe sampled on the shift clock rise
                if (load_s)
                    active_q <= stage_q;
            end
        end
    end

    // ============================================================
    // Output selection decode
    // ============================================================
    // Registered so switch controls never glitch from decode logic
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oe_q  <= 4'h0;
            idx_q <= 8'h00;
        end
        else if (ce)
        begin
            oe_q  <= {sel_en(active_q[2:0]), sel_en(active_q[5:3]),
                      sel_en(active_q[8:6]), sel_en(active_q[11:9])};
            idx_q <= {sel_idx(active_q[2:0]), sel_idx(active_q[5:3]),
                      sel_idx(active_q[8:6]), sel_idx(active_q[11:9])};
        end
    end

    assign row_forward_out      = row_out_q;
    assign column_forward_out   = col_out_q;
    assign row_forward_clock    = row_clk_q;
    assign column_forward_clock = col_clk_q;
    assign output_one_select    = active_q[11:9];
    assign output_two_select    = active_q[8:6];
    assign output_three_select  = active_q[5:3];
    assign output_four_select   = active_q[2:0];
    assign output_enable        = oe_q;
    assign input_index          = idx_q;

endmodule

`default_nettype wire

// file: xps_defines.vh
/*
 * Constants for the crosspoint serial configuration chain: control word
 * layout, start frame codes, field indices and selection codes.
 * Assumes it is included by bare name from the chain design files.
 */
`ifndef XPS_DEFINES_VH
`define XPS_DEFINES_VH

// ============================================================
// Control word layout
// ============================================================
`define XPS_WORD_LAST    5'h1d       // Index of last bit in a word (D0)
`define XPS_FRAME_LOAD   6'h1f       // Start frame: configuration load
`define XPS_FRAME_READ   6'h1e       // Start frame: configuration read
`define XPS_ROW_FIRST    5'h06       // Word index of row field MSB
`define XPS_ROW_LAST     5'h0b       // Word index of row field LSB
`define XPS_COL_FIRST    5'h0c       // Word index of column field MSB
`define XPS_COL_LAST     5'h11       // Word index of column field LSB
`define XPS_CFG_FIRST    5'h12       // Word index of first selection bit
`define XPS_SCAN_LIMIT   5'h18       // Frame scan blocked below this index
`define XPS_WORD_IN      5'h18       // Tap index once D0 has arrived
`define XPS_ADDR_ZERO    6'h00       // Address of the addressed device

// ============================================================
// Forwarding pipeline
// ============================================================
`define XPS_TAP          5           // Shift tap giving seven edge latency
`define XPS_SR_MSB       29          // Top bit of the input shift register

// ============================================================
// Selection codes and reset values
// ============================================================
`define XPS_SEL_OFF      3'h0        // Output in high impedance
`define XPS_SEL_MAX      3'h4        // Highest valid input code
`define XPS_CFG_RESET    12'h000     // All outputs off after reset

`endif

// file: xps_sync.v
/*
 * Two flip-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level relative to clk; no bus coherency.
 */
`timescale 1ns/1ps
`default_nettype none

module xps_sync
#(
    parameter W = 3                    // Number of levels
)
(
    input  wire         clk,
    input  wire         resetn,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    // ============================================================
    // Synchroniser stages
    // ============================================================
    reg [W-1:0] meta_q;                // First stage, read by stage two only
    reg [W-1:0] sync_q;                // Second stage, safe to use

    // Both stages freeze with the clock enable
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

`default_nettype wire

// file: xps_chain_checker.sv
/*
 * Port checker for the serial configuration chain.
 * Assumes ce high, slow sclk_pin and the chain top ports bound by name.
 */
`timescale 1ns/1ps
`default_nettype none

module xps_chain_checker
(
    input wire       clk,
    input wire       resetn,
    input wire       sclk_pin,
    input wire       load_pin,
    input wire       row_forward_out,
    input wire       row_forward_clock,
    input wire       column_forward_out,
    input wire       column_forward_clock,
    input wire [2:0] output_one_select,
    input wire [2:0] output_four_select,
    input wire [3:0] output_enable,
    input wire [7:0] input_index
);
    // ==========================================================
    // Clock and reset for every property
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Forwarded clocks and data timing
    // ==========================================================
    a_clk_pair: assert property (
        row_forward_clock == column_forward_clock)
        else $error("forwarded clocks differ");
    a_clk_follow: assert property (
        row_forward_clock == !$past(sclk_pin, 3))
        else $error("forwarded clock not inverted sclk");
    // Data moves only three clk after a shift clock pin rise
    a_row_moment: assert property (
        $changed(row_forward_out) |->
        $past(sclk_pin, 3) && !$past(sclk_pin, 4))
        else $error("row data moved off its slot");
    a_col_moment: assert property (
        $changed(column_forward_out) |->
        $past(sclk_pin, 3) && !$past(sclk_pin, 4))
        else $error("column data moved off its slot");

    // ==========================================================
    // Active configuration decode
    // ==========================================================
    a_en_one: assert property (
        output_enable[0] == ($past(output_one_select) inside {[3'h1:3'h4]}))
        else $error("output one enable wrong");
    a_en_four: assert property (
        output_enable[3] == ($past(output_four_select) inside {[3'h1:3'h4]}))
        else $error("output four enable wrong");
    a_idx_one: assert property (
        {1'b0, input_index[1:0]} ==
        (output_enable[0] ? $past(output_one_select) - 3'h1 : 3'h0))
        else $error("output one index wrong");
    a_idx_four: assert property (
        {1'b0, input_index[7:6]} ==
        (output_enable[3] ? $past(output_four_select) - 3'h1 : 3'h0))
        else $error("output four index wrong");
    // Active selection only moves on a strobed shift clock rise
    a_sel_hold: assert property (
        $changed(output_one_select) || $changed(output_four_select)
        |-> $past(load_pin, 3) && $past(sclk_pin, 3))
        else $error("selection moved without load");

    // ==========================================================
    // Main scenarios reached
    // ==========================================================
    c_all_on: cover property (output_enable == 4'hf);
    c_mixed: cover property (output_enable == 4'hc);
    c_col_data: cover property ($rose(column_forward_out));
endmodule

`default_nettype wire

// file: xps_nbr.sv
/*
 * Neighbour device model: captures one forwarded serial stream.
 * Assumes forwarded data is steady at each forwarded clock rise.
 */
`timescale 1ns/1ps
`default_nettype none

module xps_nbr
(
    input  wire         clk,
    input  wire         resetn,
    input  wire         fwd_clock,
    input  wire         fwd_data,
    output logic [29:0] word
);
    logic clk_prev_q;   // Last forwarded clock level, idles high

    // ==========================================================
    // Shift in on forwarded clock rise, newest bit lowest
    // ==========================================================
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_prev_q <= 1'b1;
            word       <= 30'h0000_0000;
        end
        else
        begin
            clk_prev_q <= fwd_clock;
            // Rising edge only, mid-bit of the sender
            if (fwd_clock && !clk_prev_q)
                word <= {word[28:0], fwd_data};
        end
    end
endmodule

`default_nettype wire

// file: tb.sv
/*
 * Testbench for the serial configuration chain: a host drives the pins,
 * two neighbour models capture the row and column streams.
 * Assumes a 40 MHz clk and a 200 ns shift clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk, resetn, ce, sclk, si, ld;
    wire         row_o, row_c, col_o, col_c;
    wire  [2:0]  s1, s2, s3, s4;
    wire  [3:0]  en;
    wire  [7:0]  idx;
    wire  [29:0] row_w, col_w;
    int          mismatches, cmp_count;

    xps_chain xps_chain_inst (.clk(clk), .resetn(resetn), .ce(ce),
        .sclk_pin(sclk), .si_pin(si), .load_pin(ld),
        .row_forward_out(row_o), .row_forward_clock(row_c),
        .column_forward_out(col_o), .column_forward_clock(col_c),
        .output_one_select(s1), .output_two_select(s2),
        .output_three_select(s3), .output_four_select(s4),
        .output_enable(en), .input_index(idx));
    xps_nbr row_nbr_inst (.clk(clk), .resetn(resetn), .fwd_clock(row_c),
        .fwd_data(row_o), .word(row_w));
    xps_nbr col_nbr_inst (.clk(clk), .resetn(resetn), .fwd_clock(col_c),
        .fwd_data(col_o), .word(col_w));

    // ==========================================================
    // Helpers
    // ==========================================================
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function logic [29:0] wd(input logic [5:0] f, r, c, input logic [11:0] g);
        return {f, r, c, g};
    endfunction
    // One shift clock period, 4 clk low then 4 clk high
    task bit_out(input logic b, input logic l);
        @(posedge clk);
        sclk <= 1'b0;
        si   <= b;
        ld   <= l;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // Shift clock stands low between words
    task idle;
        @(posedge clk);
        sclk <= 1'b0;
        ld   <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    // Word plus six zeros: 36 rises take D0 out of the device
    task send(input logic [29:0] w);
        for (int i = 29; i >= 0; i--)
            bit_out(w[i], 1'b0);
        repeat (6) bit_out(1'b0, 1'b0);
        idle;
    endtask
    task commit;
        bit_out(1'b0, 1'b1);
        idle;
    endtask
    task sel_chk(input logic [11:0] g, input logic [3:0] e,
                 input logic [7:0] x);
        chk({s1, s2, s3, s4}, g);
        chk(en, e);
        chk(idx, x);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task t_stage;
        send(wd(6'h1f, 6'h00, 6'h00, 12'h029c));
        chk(row_w, wd(6'h1f, 6'h00, 6'h3f, 12'h029c));
        chk(col_w, wd(6'h1f, 6'h3f, 6'h00, 12'h029c));
        sel_chk(12'h0000, 4'h0, 8'h00);
        $display("test stage done");
    endtask
    task t_forward;
        send(wd(6'h1f, 6'h02, 6'h05, 12'h029c));
        chk(row_w, wd(6'h1f, 6'h02, 6'h04, 12'h029c));
        chk(col_w, wd(6'h1f, 6'h01, 6'h05, 12'h029c));
        commit;
        sel_chk(12'h029c, 4'hf, 8'he4);
        $display("test forward and load done");
    endtask
    task t_read;
        send(wd(6'h1e, 6'h00, 6'h3f, 12'h0123));
        chk(row_w, wd(6'h1e, 6'h00, 6'h3e, 12'h0123));
        chk(col_w, wd(6'h1e, 6'h3f, 6'h3f, 12'h0123));
        send(wd(6'h1e, 6'h00, 6'h00, 12'h0000));
        chk(row_w, wd(6'h1e, 6'h00, 6'h3f, 12'h029c));
        chk(6'h3f - row_w[17:12], 6'h00);
        chk(col_w, wd(6'h1e, 6'h3f, 6'h00, 12'h029c));
        $display("test read done");
    endtask
    task t_revert;
        send(wd(6'h1f, 6'h00, 6'h00, 12'h0a0a));
        commit;
        sel_chk(12'h0a0a, 4'hc, 8'h40);
        $display("test revert done");
    endtask
    task t_unknown;
        send(wd(6'h15, 6'h00, 6'h00, 12'h0555));
        chk(row_w, wd(6'h15, 6'h00, 6'h00, 12'h0555));
        chk(col_w, wd(6'h15, 6'h00, 6'h00, 12'h0555));
        commit;
        sel_chk(12'h0a0a, 4'hc, 8'h40);
        $display("test unknown frame done");
    endtask

    // ==========================================================
    // Closing, clock, sequence and watchdog
    // ==========================================================
    task conclude;
        $display("Counts: %0d mismatches, %0d comparisons",
                 mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        ld = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_stage;
        t_forward;
        t_read;
        t_revert;
        t_unknown;
        conclude;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        conclude;
    end
endmodule

bind xps_chain xps_chain_checker xps_chain_checker_inst (.clk(clk),
    .resetn(resetn), .sclk_pin(sclk_pin), .load_pin(load_pin),
    .row_forward_out(row_forward_out), .row_forward_clock(row_forward_clock),
    .column_forward_out(column_forward_out),
    .column_forward_clock(column_forward_clock),
    .output_one_select(output_one_select),
    .output_four_select(output_four_select),
    .output_enable(output_enable), .input_index(input_index));

`default_nettype wire
